// ### design/dcc_pkg.sv
// constants, register map and state type of the dual comparator control block
package dcc_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int PORT_W = 6;
   localparam int IDX_W = 10;

   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_PORT_A_DATA = 10'h005;
   localparam logic [IDX_W-1:0] IDX_INTERRUPT_CONTROL = 10'h00b;
   localparam logic [IDX_W-1:0] IDX_PERIPHERAL_FLAGS_TWO = 10'h00d;
   localparam logic [IDX_W-1:0] IDX_PORT_A_DIRECTION = 10'h085;
   localparam logic [IDX_W-1:0] IDX_PERIPHERAL_ENABLES_TWO = 10'h08d;
   localparam logic [IDX_W-1:0] IDX_COMPARATOR_CONTROL = 10'h09c;
   localparam logic [IDX_W-1:0] IDX_REFERENCE_CONTROL = 10'h09d;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h0a0;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h0a1;

   // reset values
   localparam logic [PORT_W-1:0] RST_PORT_A_DIRECTION = 6'h3f;
   localparam logic [PORT_W-1:0] RST_PORT_A_DATA = 6'h00;
   localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
   localparam logic [7:0] RST_REFERENCE_CONTROL = 8'h00;
   localparam logic [2:0] RST_MODE = 3'h7;

   // comparator_control field positions
   localparam int CC_MODE_LSB = 0;
   localparam int CC_SWITCH_BIT = 3;
   localparam int CC_INV_LSB = 4;
   localparam int CC_RESULT_LSB = 6;

   // interrupt_control, flags and enables bit positions
   localparam int IC_GIE_BIT = 7;
   localparam int IC_PERIPHERAL_IRQ_ENABLE_BIT = 6;
   localparam int FLAG_BIT = 6;

   // reference_control: bit 4 unimplemented
   localparam logic [7:0] REF_MASK = 8'hef;
   localparam int REF_EN_BIT = 7;
   localparam int REF_OE_BIT = 6;
   localparam int REF_RANGE_BIT = 5;
   localparam int REF_VALUE_LSB = 0;

   // comparator modes
   localparam logic [2:0] MODE_RESET = 3'h0;
   localparam logic [2:0] MODE_PIN_OUT = 3'h3;
   localparam logic [2:0] MODE_INT_REF = 3'h6;
   localparam logic [2:0] MODE_OFF = 3'h7;
   localparam logic [PORT_W-1:0] ANALOG_MASK_ON = 6'h0f;
   localparam int FIRST_PIN = 4;
   localparam int SECOND_PIN = 5;

   // irq_status / irq_mask layout
   localparam int IRQ_CHANGE_BIT = 0;
   localparam int IRQ_SOFT_BIT = 1;
   localparam logic [1:0] RST_IRQ = 2'h0;

   typedef struct packed {
      logic [PORT_W-1:0] port_latch;
      logic [PORT_W-1:0] direction;
      logic [7:0] interrupt_control;
      logic compare_change_flag;
      logic compare_change_enable;
      logic [2:0] comparator_mode_field;
      logic input_switch;
      logic [1:0] result_invert;
      logic [1:0] compare_result;
      logic [1:0] latched_result;
      logic [7:0] reference_control;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic pready;
      logic [DATA_W-1:0] prdata;
      logic pslverr;
      logic irq;
      logic core_irq;
      logic wake_request;
      logic [PORT_W-1:0] analog_mask;
      logic [1:0] compare_enable;
      logic ref_to_positive;
   } dcc_state_type;

endpackage

// ### design/dcc_top.sv
// dual comparator control: apb registers, result routing and change interrupt
// Functional notes
// [R1] three-bit mode field picks eight modes
// [R2] raw result high when positive exceeds negative
// [R3] mode 110 feeds reference to positive inputs
// [R4] result bits seven and six read-only
// [R5] routed pins follow results without synchronising
// [R6] direction bits still gate routed pin drivers
// [R7] bits four and five invert each result
// [R8] analog pins read zero in port data
// [R9] result change sets change flag
// [R10] writing zero clears flag, one sets
// [R11] core request needs all three enables
// [R12] change during control read may miss; here a change in the access cycle still sets the flag
// [R13] control access ends mismatch, clear works after
// [R14] persisting mismatch keeps setting flag
// [R15] comparators run in sleep, enabled flag wakes
// [R16] sleep wake leaves control register unchanged
// [R17] reset loads control register, mode off
// [R18] software masks interrupts during mode changes
// [R19] access latches results; difference means mismatch
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
module dcc_top (
   input wire logic CLOCK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [dcc_pkg::ADDR_W-1:0] PADDR,
   input wire logic [dcc_pkg::DATA_W-1:0] PWDATA,
   output logic PREADY,
   output logic [dcc_pkg::DATA_W-1:0] PRDATA,
   output logic PSLVERR,
   input wire logic FIRST_RAW,
   input wire logic SECOND_RAW,
   input wire logic [dcc_pkg::PORT_W-1:0] PIN_IN,
   output logic [dcc_pkg::PORT_W-1:0] PIN_OUT,
   output logic [dcc_pkg::PORT_W-1:0] PIN_OE_N,
   output logic [dcc_pkg::PORT_W-1:0] ANALOG_PIN_MASK,
   output logic [1:0] COMPARE_ENABLE,
   output logic REF_TO_POSITIVE,
   output logic INPUT_SWITCH,
   output logic REF_ENABLE,
   output logic REF_OUT_ENABLE,
   output logic REF_RANGE,
   output logic [3:0] REF_VALUE,
   output logic CORE_IRQ,
   output logic WAKE_REQUEST,
   output logic IRQ
);
   import dcc_pkg::*;

   dcc_state_type state;
   dcc_state_type next_state;

   logic [IDX_W-1:0] index;
   logic aligned;
   logic setup;
   logic done;
   logic do_write;
   logic do_read;
   logic comparators_on;
   logic pins_routed;
   logic [1:0] live_result;
   logic [1:0] pin_result;
   logic [PORT_W-1:0] analog_mask;
   logic mismatch;
   logic [7:0] control_view;
   logic [7:0] read_byte;
   logic hit;

   assign index = PADDR[ADDR_W-1:2];
   assign aligned = (PADDR[1:0] == 2'h0);
   assign setup = PSEL && !PENABLE;
   // pready is high only in the access cycle, so completion is this term
   assign done = PSEL && PENABLE && state.pready;
   assign do_write = done && PWRITE && !state.pslverr;
   assign do_read = done && !PWRITE && !state.pslverr;

   // mode field selects routing; reset and off modes park the comparators
   assign comparators_on = (state.comparator_mode_field != MODE_OFF)
      && (state.comparator_mode_field != MODE_RESET); // [R1]
   assign pins_routed = (state.comparator_mode_field == MODE_PIN_OUT); // [R1]
   assign analog_mask = state.analog_mask;

   // raw inputs already high for positive above negative
   assign live_result = comparators_on ? ({SECOND_RAW, FIRST_RAW} ^ state.result_invert)
      : 2'h0; // [R2] [R7]
   // routed path bypasses every flop: a pin sees the comparator with no clock delay
   assign pin_result = {SECOND_RAW, FIRST_RAW} ^ state.result_invert; // [R5] [R7]

   assign mismatch = (state.compare_result != state.latched_result); // [R19]

   assign control_view = {state.compare_result, state.result_invert, state.input_switch,
      state.comparator_mode_field};

   always_comb
   begin
      hit = 1'b1;
      read_byte = 8'h00;
      unique case (index)
         IDX_PORT_A_DATA:
         begin
            read_byte = {2'h0, PIN_IN & ~analog_mask}; // [R8]
         end
         IDX_INTERRUPT_CONTROL:
         begin
            read_byte = state.interrupt_control;
         end
         IDX_PERIPHERAL_FLAGS_TWO:
         begin
            read_byte[FLAG_BIT] = state.compare_change_flag;
         end
         IDX_PORT_A_DIRECTION:
         begin
            read_byte = {2'h0, state.direction};
         end
         IDX_PERIPHERAL_ENABLES_TWO:
         begin
            read_byte[FLAG_BIT] = state.compare_change_enable;
         end
         IDX_COMPARATOR_CONTROL:
         begin
            read_byte = control_view;
         end
         IDX_REFERENCE_CONTROL:
         begin
            read_byte = state.reference_control;
         end
         IDX_IRQ_STATUS:
         begin
            read_byte = {6'h00, state.irq_status};
         end
         IDX_IRQ_MASK:
         begin
            read_byte = {6'h00, state.irq_mask};
         end
         default:
         begin
            hit = 1'b0;
         end
      endcase
   end

   always_comb
   begin
      next_state = state;

      // bus slave: one wait-free access cycle, data and error staged in setup
      next_state.pready = setup;
      next_state.pslverr = setup && !(hit && aligned);
      if (setup)
      begin
         next_state.prdata = {24'h000000, (hit && aligned && !PWRITE) ? read_byte : 8'h00};
      end
      else if (done)
      begin
         next_state.prdata = '0;
      end

      // results sampled every cycle, asleep or not
      next_state.compare_result = live_result; // [R15]

      if (do_write)
      begin
         unique case (index)
            IDX_PORT_A_DATA:
            begin
               next_state.port_latch = PWDATA[PORT_W-1:0];
            end
            IDX_INTERRUPT_CONTROL:
            begin
               next_state.interrupt_control = PWDATA[7:0];
            end
            IDX_PERIPHERAL_FLAGS_TWO:
            begin
               next_state.compare_change_flag = PWDATA[FLAG_BIT]; // [R10]
            end
            IDX_PORT_A_DIRECTION:
            begin
               next_state.direction = PWDATA[PORT_W-1:0];
            end
            IDX_PERIPHERAL_ENABLES_TWO:
            begin
               next_state.compare_change_enable = PWDATA[FLAG_BIT];
            end
            IDX_COMPARATOR_CONTROL:
            begin
               // result bits are not written
               next_state.comparator_mode_field = PWDATA[CC_MODE_LSB +: 3]; // [R1] [R4]
               next_state.input_switch = PWDATA[CC_SWITCH_BIT];
               next_state.result_invert = PWDATA[CC_INV_LSB +: 2]; // [R7]
            end
            IDX_REFERENCE_CONTROL:
            begin
               next_state.reference_control = PWDATA[7:0] & REF_MASK;
            end
            IDX_IRQ_MASK:
            begin
               next_state.irq_mask = PWDATA[1:0];
            end
            default:
            begin
               next_state.irq_mask = state.irq_mask;
            end
         endcase
      end

      // routing outputs registered from the mode field they will follow
      next_state.analog_mask = (next_state.comparator_mode_field == MODE_OFF) ? '0
         : ANALOG_MASK_ON; // [R1]
      next_state.compare_enable = ((next_state.comparator_mode_field == MODE_OFF)
         || (next_state.comparator_mode_field == MODE_RESET)) ? 2'h0 : 2'h3; // [R1]
      next_state.ref_to_positive = (next_state.comparator_mode_field == MODE_INT_REF); // [R3]

      // status read clears only what the read returned, so nothing is lost
      if (do_read && index == IDX_IRQ_STATUS)
      begin
         next_state.irq_status = state.irq_status & ~state.prdata[1:0];
      end

      // any error-free access to the control register refreshes the latched copy;
      // a change in that very cycle still differs from the latched copy and raises the flag
      if (done && !state.pslverr && index == IDX_COMPARATOR_CONTROL)
      begin
         next_state.latched_result = state.compare_result; // [R13] [R19] [R12]
      end

      // mismatch keeps setting the flag and wins over a software clear
      if (mismatch)
      begin
         next_state.compare_change_flag = 1'b1; // [R9] [R14] [R13]
      end

      // sticky status events, set wins over the read clear
      if (live_result != state.compare_result)
      begin
         next_state.irq_status[IRQ_CHANGE_BIT] = 1'b1;
      end
      if (do_write && index == IDX_PERIPHERAL_FLAGS_TWO && PWDATA[FLAG_BIT])
      begin
         next_state.irq_status[IRQ_SOFT_BIT] = 1'b1;
      end

      next_state.irq = |(next_state.irq_status & next_state.irq_mask);
      // flag is set regardless; only the core and wake requests are gated
      next_state.core_irq = next_state.compare_change_flag
         && next_state.compare_change_enable
         && next_state.interrupt_control[IC_PERIPHERAL_IRQ_ENABLE_BIT]
         && next_state.interrupt_control[IC_GIE_BIT]; // [R11]
      // wake needs no global enable, as the core is stopped anyway
      next_state.wake_request = next_state.compare_change_flag
         && next_state.compare_change_enable
         && next_state.interrupt_control[IC_PERIPHERAL_IRQ_ENABLE_BIT]; // [R15]
   end

   // besides bus writes and result sampling, only reset touches the control register; sleep has no path here
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         state <= '0;
         state.direction <= RST_PORT_A_DIRECTION;
         state.port_latch <= RST_PORT_A_DATA;
         state.interrupt_control <= RST_INTERRUPT_CONTROL;
         state.reference_control <= RST_REFERENCE_CONTROL;
         state.comparator_mode_field <= RST_MODE; // [R17] [R16]
         state.irq_status <= RST_IRQ;
         state.irq_mask <= RST_IRQ;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign PREADY = state.pready;
   assign PRDATA = state.prdata;
   assign PSLVERR = state.pslverr;
   assign IRQ = state.irq;
   assign CORE_IRQ = state.core_irq;
   assign WAKE_REQUEST = state.wake_request;
   assign ANALOG_PIN_MASK = state.analog_mask;
   assign COMPARE_ENABLE = state.compare_enable;
   assign REF_TO_POSITIVE = state.ref_to_positive; // [R3]
   assign INPUT_SWITCH = state.input_switch;
   assign REF_ENABLE = state.reference_control[REF_EN_BIT];
   assign REF_OUT_ENABLE = state.reference_control[REF_OE_BIT];
   assign REF_RANGE = state.reference_control[REF_RANGE_BIT];
   assign REF_VALUE = state.reference_control[REF_VALUE_LSB +: 4];

   // pin drive: plain latch outside routed mode; first pin is open drain
   genvar g;
   generate
      for (g = 0; g < PORT_W; g++)
      begin : g_pin
         if (g == FIRST_PIN)
         begin : g_od
            logic level;
            assign level = pins_routed ? pin_result[0] : state.port_latch[g]; // [R5]
            assign PIN_OUT[g] = 1'b0;
            assign PIN_OE_N[g] = state.direction[g] | level; // [R6]
         end
         else if (g == SECOND_PIN)
         begin : g_pp
            assign PIN_OUT[g] = pins_routed ? pin_result[1] : state.port_latch[g]; // [R5]
            assign PIN_OE_N[g] = state.direction[g]; // [R6]
         end
         else
         begin : g_plain
            assign PIN_OUT[g] = state.port_latch[g];
            assign PIN_OE_N[g] = state.direction[g];
         end
      end
   endgenerate

endmodule

// ### tb/dcc_properties.sv
// port-level assertions for the dual comparator control block
`timescale 1ns/10ps
module dcc_properties (
   input wire logic CLOCK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire logic [dcc_pkg::DATA_W-1:0] PRDATA,
   input wire logic PSLVERR,
   input wire logic [dcc_pkg::PORT_W-1:0] ANALOG_PIN_MASK,
   input wire logic [1:0] COMPARE_ENABLE,
   input wire logic REF_TO_POSITIVE,
   input wire logic CORE_IRQ,
   input wire logic WAKE_REQUEST
);
   import dcc_pkg::*;
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESET_N);
   property p_setup_ready;
      PSEL && !PENABLE |=> PREADY;
   endproperty
   a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
   property p_ready_pulse;
      PREADY |=> !PREADY;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
   property p_err_data;
      PSLVERR |-> PREADY && PRDATA == 32'h00000000;
   endproperty
   a_err_data: assert property (p_err_data) else $error("error without ready or with data");
   property p_idle_data;
      !PREADY |-> PRDATA == 32'h00000000;
   endproperty
   a_idle_data: assert property (p_idle_data) else $error("read data outside access");
   property p_upper_zero;
      PREADY |-> PRDATA[31:8] == 24'h000000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
   property p_core_wake;
      CORE_IRQ |-> WAKE_REQUEST;
   endproperty
   a_core_wake: assert property (p_core_wake) else $error("core request without wake");
   property p_ref_mode;
      REF_TO_POSITIVE |-> COMPARE_ENABLE == 2'b11 && ANALOG_PIN_MASK == 6'h0f;
   endproperty
   a_ref_mode: assert property (p_ref_mode) else $error("reference mode inconsistent");
   property p_off_mode;
      ANALOG_PIN_MASK == 6'h00 |-> COMPARE_ENABLE == 2'b00 && !REF_TO_POSITIVE;
   endproperty
   a_off_mode: assert property (p_off_mode) else $error("off mode inconsistent");
   property p_reset_off;
      $rose(RESET_N) |-> (ANALOG_PIN_MASK == 6'h00) [*2];
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("not off after reset");
endmodule
bind dcc_top dcc_properties u_props (.CLOCK(CLOCK), .RESET_N(RESET_N), .PSEL(PSEL),
   .PENABLE(PENABLE), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
   .ANALOG_PIN_MASK(ANALOG_PIN_MASK), .COMPARE_ENABLE(COMPARE_ENABLE),
   .REF_TO_POSITIVE(REF_TO_POSITIVE), .CORE_IRQ(CORE_IRQ), .WAKE_REQUEST(WAKE_REQUEST));

// ### tb/dcc_analog_model.sv
// behavioural analog front end: two comparators and the internal reference
`timescale 1ns/10ps
module dcc_analog_model (
   input wire logic [7:0] first_pos,
   input wire logic [7:0] first_neg,
   input wire logic [7:0] second_pos,
   input wire logic [7:0] second_neg,
   input wire logic ref_to_positive,
   input wire logic [3:0] ref_value,
   output logic first_raw,
   output logic second_raw
);
   logic [7:0] ref_level;
   assign ref_level = {ref_value, 4'h0};
   // reference replaces both positive inputs
   assign first_raw = (ref_to_positive ? ref_level : first_pos) > first_neg;
   assign second_raw = (ref_to_positive ? ref_level : second_pos) > second_neg;
endmodule

// ### tb/testbench.sv
// self-checking bench for the dual comparator control block
`timescale 1ns/10ps
module testbench;
   import dcc_pkg::*;
   localparam logic [IDX_W-1:0] ctl = IDX_COMPARATOR_CONTROL;
   localparam logic [IDX_W-1:0] flg = IDX_PERIPHERAL_FLAGS_TWO;
   logic clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 12'h000;
   logic [DATA_W-1:0] pwdata = 32'h00000000, prdata, rd;
   logic pready, pslverr, err, first_raw, second_raw, ref_pos, core_irq, wake, irq;
   logic ref_en, ref_oe, ref_rng, in_sw;
   logic [PORT_W-1:0] pin_in = 6'h00, pin_out, pin_oe_n, amask;
   logic [1:0] cen, inv;
   logic [3:0] ref_val;
   logic [7:0] a1p = 8'h00, a1n = 8'h80, a2p = 8'h00, a2n = 8'h80;
   int fail_count = 0, n_checks = 0;
   always #5 clock = ~clock;
   dcc_top dut (.CLOCK(clock), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
      .PSLVERR(pslverr), .FIRST_RAW(first_raw), .SECOND_RAW(second_raw), .PIN_IN(pin_in),
      .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .ANALOG_PIN_MASK(amask), .COMPARE_ENABLE(cen),
      .REF_TO_POSITIVE(ref_pos), .INPUT_SWITCH(in_sw), .REF_ENABLE(ref_en),
      .REF_OUT_ENABLE(ref_oe), .REF_RANGE(ref_rng), .REF_VALUE(ref_val),
      .CORE_IRQ(core_irq), .WAKE_REQUEST(wake), .IRQ(irq));
   dcc_analog_model analog (.first_pos(a1p), .first_neg(a1n), .second_pos(a2p),
      .second_neg(a2n), .ref_to_positive(ref_pos), .ref_value(ref_val),
      .first_raw(first_raw), .second_raw(second_raw));
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // request held until ready is sampled high
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] v);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, v};
      @(posedge clock);
      penable <= 1'b1;
      do
         @(posedge clock);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] v);
      apb(1'b1, {i, 2'b00}, v);
   endtask
   task automatic rdchk(input string what, input logic [IDX_W-1:0] i, input logic [7:0] e);
      apb(1'b0, {i, 2'b00}, 8'h00);
      check(what, rd, {24'h000000, e});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   function automatic logic [1:0] expres(input logic [1:0] iv, input logic useref);
      return {(useref ? 8'hf0 : a2p) > a2n, (useref ? 8'hf0 : a1p) > a1n} ^ iv;
   endfunction
   initial
   begin
      #100000;
      fail_count++;
      summarize();
   end
   initial
   begin
      void'($urandom(34));
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      rdchk("control reset", ctl, 8'h07);
      rdchk("direction reset", IDX_PORT_A_DIRECTION, 8'h3f);
      for (int m = 0; m < 8; m++)
      begin
         wr(ctl, 8'(m));
         tick(1);
         check("compare enable", cen, (m == 0 || m == 7) ? 2'b00 : 2'b11);
         check("ref to positive", ref_pos, m == 6);
         check("analog mask", amask, (m == 7) ? 6'h00 : 6'h0f);
      end
      $display("mode test done");
      for (int i = 0; i < 8; i++)
      begin
         inv = 2'($urandom);
         wr(ctl, {2'b11, inv, 4'h2});
         @(posedge clock);
         a1p <= 8'($urandom) | 8'h01;
         a2p <= 8'($urandom) | 8'h01;
         tick(2);
         rdchk("results", ctl, {expres(inv, 1'b0), inv, 4'h2});
      end
      wr(IDX_REFERENCE_CONTROL, 8'hff);
      rdchk("reference control", IDX_REFERENCE_CONTROL, 8'hef);
      check("reference outputs", {ref_en, ref_oe, ref_rng, ref_val}, 7'h7f);
      wr(ctl, 8'h0e);
      @(posedge clock);
      a1p <= 8'h00;
      a2p <= 8'h00;
      tick(2);
      check("input switch", in_sw, 1'b1);
      rdchk("reference results", ctl, {expres(2'b00, 1'b1), 6'h0e});
      $display("result test done");
      wr(IDX_PORT_A_DIRECTION, 8'h0f);
      wr(IDX_PORT_A_DATA, 8'h15);
      wr(ctl, 8'h03);
      @(posedge clock);
      a2p <= 8'hff;
      #1;
      check("second pin", pin_out[SECOND_PIN], 1'b1);
      check("pin enables", pin_oe_n[5:4], 2'b00);
      check("latched pins", pin_out[3:0], 4'h5);
      @(posedge clock);
      a1p <= 8'hff;
      #1;
      // open drain: a high result releases the pin to its pull-up
      check("open drain high", pin_oe_n[FIRST_PIN], 1'b1);
      @(posedge clock);
      a1p <= 8'h00;
      wr(IDX_PORT_A_DIRECTION, 8'h3f);
      tick(1);
      check("pins released", pin_oe_n[5:4], 2'b11);
      wr(ctl, 8'h02);
      pin_in <= 6'($urandom);
      tick(1);
      rdchk("port analog", IDX_PORT_A_DATA, {2'b00, pin_in[5:4], 4'h0});
      wr(ctl, 8'h07);
      rdchk("port digital", IDX_PORT_A_DATA, {2'b00, pin_in});
      $display("pin test done");
      // mode changed while interrupts are still off, stale flag cleared first
      wr(ctl, 8'h02);
      tick(2);
      rdchk("no mismatch", ctl, {expres(2'b00, 1'b0), 6'h02});
      wr(flg, 8'h00);
      wr(IDX_INTERRUPT_CONTROL, 8'hc0);
      wr(IDX_PERIPHERAL_ENABLES_TWO, 8'h40);
      wr(IDX_IRQ_MASK, 8'h03);
      apb(1'b0, {IDX_IRQ_STATUS, 2'b00}, 8'h00);
      tick(2);
      check("irq idle", {core_irq, wake, irq}, 3'b000);
      @(posedge clock);
      a1p <= 8'hff;
      tick(3);
      check("change irq", {core_irq, wake, irq}, 3'b111);
      wr(flg, 8'h00);
      rdchk("flag held", flg, 8'h40);
      rdchk("control read", ctl, {expres(2'b00, 1'b0), 6'h02});
      wr(flg, 8'h00);
      rdchk("flag cleared", flg, 8'h00);
      tick(1);
      check("irq cleared", {core_irq, wake}, 2'b00);
      wr(IDX_INTERRUPT_CONTROL, 8'h40);
      wr(flg, 8'h40);
      rdchk("soft flag", flg, 8'h40);
      tick(1);
      check("global off", {core_irq, wake}, 2'b01);
      apb(1'b0, {IDX_IRQ_STATUS, 2'b00}, 8'h00);
      check("status change", rd[1:0], 2'b11);
      rdchk("status cleared", IDX_IRQ_STATUS, 8'h00);
      wr(IDX_IRQ_MASK, 8'h00);
      @(posedge clock);
      a1p <= 8'h00;
      tick(3);
      check("masked irq", irq, 1'b0);
      wr(IDX_IRQ_MASK, 8'h01);
      tick(2);
      check("unmasked irq", irq, 1'b1);
      $display("interrupt test done");
      apb(1'b0, 12'hffc, 8'h00);
      check("unmapped error", err, 1'b1);
      check("unmapped data", rd, 32'h00000000);
      apb(1'b1, 12'h271, 8'h00);
      check("unaligned error", err, 1'b1);
      rdchk("control kept", ctl, {expres(2'b00, 1'b0), 6'h02});
      $display("error test done");
      @(posedge clock);
      reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      #1;
      check("reset outputs", {amask, cen, pin_oe_n, core_irq, wake, irq}, 17'h001f8);
      rdchk("control after reset", ctl, 8'h07);
      $display("reset test done");
      summarize();
   end
endmodule
